// file: include/iohs_pkg.sv
// Package with register map, field positions and carrier types for the output hold block.
package iohs_pkg;
   localparam int NUM_POINTS = 16;
   localparam int STATUS_USED = 11;
   // Register byte offsets on the Wishbone bus.
   localparam logic [7:0] REG_OUT_CMD = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
   localparam logic [7:0] REG_IRQ_CLR = 8'h10;
   localparam logic [7:0] REG_IRQ_EN = 8'h14;
   localparam logic [7:0] REG_POINTS = 8'h18;
   // Config register fields.
   localparam int CFG_LINK_OK_BIT = 0;
   localparam int CFG_SW_HOLD_BIT = 1;
   // Status word fields.
   localparam int ST_TERM_PRESENT_BIT = 0;
   localparam int ST_SWITCH_HOLD_BIT = 1;
   localparam int ST_MODE_MISMATCH_BIT = 2;
   localparam int ST_LINK_OK_BIT = 3;
   localparam int ST_BP_POWER_BIT = 4;
   localparam int ST_FIELD_POWER_BIT = 5;
   localparam int ST_HOLDING_BIT = 6;
   localparam int ST_NOT_READY_BIT = 9;
   // Interrupt event bits.
   localparam int EV_MISMATCH = 0;
   localparam int EV_LINK_LOST = 1;
   localparam int EV_TERM_CHANGE = 2;
   localparam int EV_POWER_LOST = 3;
   localparam int NUM_EVENTS = 4;
   localparam logic [15:0] RST_OUT_CMD = 16'h0000;
   localparam logic [1:0] RST_CONFIG = 2'h0;
   localparam logic [3:0] RST_IRQ_EN = 4'h0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } iohs_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } iohs_wb_rsp_t;

   typedef struct packed {
      logic upper_switch_hold;
      logic lower_switch;
      logic backplane_power;
      logic field_power;
      logic terminal_present;
   } iohs_field_t;
endpackage : iohs_pkg

// file: design/iohs_core.sv
// Sixteen point isolated output block with hold-last-state defaults and status word.
//
// Behaviour
// - Sixteen output points, each switched independently from its commanded value.
// - Switch open selects force off when controller communication is lost.
// - Switch left holds the last commanded values while communication is lost.
// - Hold needs backplane and field power; otherwise outputs go to default off.
// - Switch mode differing from software configured mode raises a warning event.
// - Only the upper selection switch chooses the default mode; lower is ignored.
// - Sixteen bit status word sent; only the low ten bits carry information.
// - Status bit 9 high means the module is not ready.
// - Terminal block presence is reported in the status word.
// - Terminal indicator is green when block fitted, red when absent.
// - One indicator per output point shows whether the point is on.
`timescale 1ns/1ps
module iohs_core (
   input wire logic clk,
   input wire logic rst,
   input wire iohs_pkg::iohs_wb_req_t wb_req,
   output iohs_pkg::iohs_wb_rsp_t wb_rsp,
   input wire iohs_pkg::iohs_field_t field_in,
   output logic [15:0] points,
   output logic [15:0] point_leds,
   output logic term_led_green,
   output logic term_led_red,
   output logic irq
);
   import iohs_pkg::*;

   logic [15:0] out_cmd;
   logic link_ok;
   logic cfg_hold;
   logic [NUM_EVENTS-1:0] irq_stat;
   logic [NUM_EVENTS-1:0] irq_en;
   logic ack;
   logic [31:0] rd_data;
   logic prev_link_ok;
   logic prev_term;
   logic prev_power;
   logic prev_mismatch;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   // Bus decode.
   wire bus_go = wb_req.cyc && wb_req.stb && !ack;
   // A write lands at the edge where the master sees ack high, while the request still stands.
   wire wr_go = wb_req.cyc && wb_req.stb && wb_req.we && ack;
   wire [31:0] wr_merged = merge_bytes(32'h00000000, wb_req.dat, wb_req.sel);
   wire wr_cmd = wr_go && (wb_req.adr == REG_OUT_CMD);
   wire wr_cfg = wr_go && (wb_req.adr == REG_CONFIG);
   wire wr_clr = wr_go && (wb_req.adr == REG_IRQ_CLR);
   wire wr_en = wr_go && (wb_req.adr == REG_IRQ_EN);
   wire [31:0] cmd_merged = merge_bytes({16'h0000, out_cmd}, wb_req.dat, wb_req.sel);
   wire [31:0] cfg_merged = merge_bytes({30'h00000000, cfg_hold, link_ok}, wb_req.dat,
                                        wb_req.sel);

   // Mode and output selection; the lower switch is never read.
   wire switch_hold = field_in.upper_switch_hold;
   wire power_ok = field_in.backplane_power && field_in.field_power;
   wire holding = !link_ok && switch_hold && power_ok;
   wire mismatch = switch_hold != cfg_hold;
   wire not_ready = !(link_ok && power_ok);
   wire [15:0] next_points = link_ok && power_ok ? out_cmd :
                             holding ? points : 16'h0000;

   wire [15:0] status_word;
   assign status_word[ST_TERM_PRESENT_BIT] = field_in.terminal_present;
   assign status_word[ST_SWITCH_HOLD_BIT] = switch_hold;
   assign status_word[ST_MODE_MISMATCH_BIT] = mismatch;
   assign status_word[ST_LINK_OK_BIT] = link_ok;
   assign status_word[ST_BP_POWER_BIT] = field_in.backplane_power;
   assign status_word[ST_FIELD_POWER_BIT] = field_in.field_power;
   assign status_word[ST_HOLDING_BIT] = holding;
   assign status_word[8:7] = 2'h0;
   assign status_word[ST_NOT_READY_BIT] = not_ready;
   assign status_word[15:10] = 6'h00;

   wire [NUM_EVENTS-1:0] events;
   assign events[EV_MISMATCH] = mismatch && !prev_mismatch;
   assign events[EV_LINK_LOST] = prev_link_ok && !link_ok;
   assign events[EV_TERM_CHANGE] = prev_term != field_in.terminal_present;
   assign events[EV_POWER_LOST] = prev_power && !power_ok;

   // A new event in the clear cycle survives the clear.
   wire [NUM_EVENTS-1:0] clr_mask = wr_clr ? wr_merged[NUM_EVENTS-1:0] : '0;
   wire [NUM_EVENTS-1:0] next_irq_stat = (irq_stat & ~clr_mask) | events;

   always_comb begin
      rd_data = UNMAPPED_DATA;
      case (wb_req.adr)
         REG_OUT_CMD: rd_data = {16'h0000, out_cmd};
         REG_CONFIG: rd_data = {30'h00000000, cfg_hold, link_ok};
         REG_STATUS: rd_data = {16'h0000, status_word};
         REG_IRQ_STAT: rd_data = {28'h0000000, irq_stat};
         REG_IRQ_EN: rd_data = {28'h0000000, irq_en};
         REG_POINTS: rd_data = {16'h0000, points};
         default: rd_data = UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack <= 1'b0;
         wb_rsp <= '0;
      end else begin
         ack <= bus_go;
         wb_rsp.ack <= bus_go;
         wb_rsp.dat <= bus_go ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_cmd <= RST_OUT_CMD;
         {cfg_hold, link_ok} <= RST_CONFIG;
         irq_en <= RST_IRQ_EN;
      end else begin
         if (wr_cmd) begin
            out_cmd <= cmd_merged[15:0];
         end
         if (wr_cfg) begin
            link_ok <= cfg_merged[CFG_LINK_OK_BIT];
            cfg_hold <= cfg_merged[CFG_SW_HOLD_BIT];
         end
         if (wr_en) begin
            irq_en <= wr_merged[NUM_EVENTS-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         points <= 16'h0000;
         irq_stat <= '0;
         prev_link_ok <= 1'b0;
         // Loading the pin level avoids a false terminal change event right after reset.
         prev_term <= field_in.terminal_present;
         prev_power <= 1'b0;
         prev_mismatch <= 1'b0;
      end else begin
         points <= next_points;
         irq_stat <= next_irq_stat;
         prev_link_ok <= link_ok;
         prev_term <= field_in.terminal_present;
         prev_power <= power_ok;
         prev_mismatch <= mismatch;
      end
   end

   assign point_leds = points;
   assign term_led_green = field_in.terminal_present;
   assign term_led_red = !field_in.terminal_present;
   assign irq = |(irq_stat & irq_en);

   // Checks.
   follow_cmd_a: assert property (@(posedge clk) disable iff (rst)
      link_ok && power_ok |=> points == $past(out_cmd))
      else $error("outputs do not follow command");
   force_off_a: assert property (@(posedge clk) disable iff (rst)
      !link_ok && !switch_hold |=> points == 16'h0000)
      else $error("outputs not forced off");
   hold_last_a: assert property (@(posedge clk) disable iff (rst)
      $past(holding) && holding |-> $stable(points))
      else $error("outputs not held");
   power_default_a: assert property (@(posedge clk) disable iff (rst)
      !power_ok |=> points == 16'h0000)
      else $error("outputs not defaulted without power");
   mismatch_event_a: assert property (@(posedge clk) disable iff (rst)
      $rose(mismatch) |=> irq_stat[EV_MISMATCH])
      else $error("mismatch not flagged");
   not_ready_bit_a: assert property (@(posedge clk) disable iff (rst)
      status_word[ST_NOT_READY_BIT] == !(link_ok && power_ok))
      else $error("not ready bit wrong");
   upper_bits_a: assert property (@(posedge clk) disable iff (rst)
      wb_rsp.ack && $past(wb_req.adr) == REG_STATUS |-> wb_rsp.dat[31:11] == 21'h000000)
      else $error("unused status bits set");
   term_report_a: assert property (@(posedge clk) disable iff (rst)
      status_word[ST_TERM_PRESENT_BIT] == term_led_green && term_led_green != term_led_red)
      else $error("terminal report wrong");
   led_track_a: assert property (@(posedge clk) disable iff (rst)
      point_leds == points)
      else $error("point indicators wrong");
   ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
      wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack held too long");
   ack_follows_a: assert property (@(posedge clk) disable iff (rst)
      bus_go |=> wb_rsp.ack)
      else $error("request not answered");
   dat_idle_a: assert property (@(posedge clk) disable iff (rst)
      !wb_rsp.ack |-> wb_rsp.dat == 32'h00000000)
      else $error("read data not zero outside ack");
   cmd_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_cmd && wb_req.sel == 4'hf |=> out_cmd == $past(wb_req.dat[15:0]))
      else $error("command write lost");
   link_event_a: assert property (@(posedge clk) disable iff (rst)
      $fell(link_ok) |=> irq_stat[EV_LINK_LOST])
      else $error("link loss not flagged");
   term_event_a: assert property (@(posedge clk) disable iff (rst)
      $changed(field_in.terminal_present) |=> irq_stat[EV_TERM_CHANGE])
      else $error("terminal change not flagged");
   power_event_a: assert property (@(posedge clk) disable iff (rst)
      $fell(power_ok) |=> irq_stat[EV_POWER_LOST])
      else $error("power loss not flagged");
   sticky_stat_a: assert property (@(posedge clk) disable iff (rst)
      !wr_clr |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
      else $error("status bit dropped without clear");
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      |events |=> (irq_stat & $past(events)) == $past(events))
      else $error("event lost against clear");
   clear_stat_a: assert property (@(posedge clk) disable iff (rst)
      wr_clr |=> (irq_stat & $past(clr_mask) & ~$past(events)) == '0)
      else $error("status bit not cleared");
   irq_level_a: assert property (@(posedge clk) disable iff (rst)
      (irq_stat[EV_MISMATCH] && irq_en[EV_MISMATCH]) |-> irq)
      else $error("interrupt not raised");
   hold_power_a: assert property (@(posedge clk) disable iff (rst)
      status_word[ST_HOLDING_BIT] |-> field_in.backplane_power && field_in.field_power)
      else $error("holding reported without power");
   reset_out_a: assert property (@(posedge clk)
      $past(rst) |-> points == 16'h0000 && !wb_rsp.ack)
      else $error("outputs not cleared by reset");

   hold_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(holding));
   force_seen_c: cover property (@(posedge clk) disable iff (rst)
      $fell(link_ok) && !switch_hold);
   irq_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(irq));
   mismatch_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(mismatch));
   power_drop_c: cover property (@(posedge clk) disable iff (rst) $fell(power_ok));
endmodule : iohs_core

// file: tb/iohs_ctl_model.sv
// Controller model that reaches the block registers as a classic Wishbone master.
`timescale 1ns/1ps
module iohs_ctl_model (
   input wire logic clk,
   input wire iohs_pkg::iohs_wb_rsp_t wb_rsp,
   output iohs_pkg::iohs_wb_req_t wb_req
);
   import iohs_pkg::*;
   initial wb_req = '0;
   // Every read takes the full 32-bit word, so the 16-bit status area is never cut short.
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
      do @(posedge clk); while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      // Released data shows the inverse, so a stale value cannot pass for a held one.
      wb_req <= '{1'b0, 1'b0, 1'b0, 8'h00, 4'h0, ~wd};
      @(posedge clk);
   endtask : xfer
endmodule : iohs_ctl_model

// file: tb/tb_top.sv
// Self-checking bench for the isolated output hold block.
`timescale 1ns/1ps
module tb_top;
   import iohs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   iohs_wb_req_t req;
   iohs_wb_rsp_t rsp;
   iohs_field_t fld = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic [15:0] points;
   logic [15:0] point_leds;
   logic term_led_green;
   logic term_led_red;
   logic irq;
   int errors = 0;
   int tests_run = 0;
   always #12.5 clk = ~clk;
   iohs_core dut (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .field_in(fld),
      .points(points), .point_leds(point_leds), .term_led_green(term_led_green),
      .term_led_red(term_led_red), .irq(irq));
   iohs_ctl_model ctl (.clk(clk), .wb_rsp(rsp), .wb_req(req));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ctl.xfer(1'b1, a, d, r);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      ctl.xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask : rdc
   task automatic idle();
      repeat (3) @(posedge clk);
   endtask : idle
   function automatic logic [31:0] st(input logic lk, input logic ch);
      logic sw;
      logic pw;
      sw = fld.upper_switch_hold;
      pw = fld.backplane_power & fld.field_power;
      st = {22'h0, !(lk & pw), 2'h0, sw & pw & !lk, fld.field_power,
         fld.backplane_power, lk, sw ^ ch, sw, fld.terminal_present};
   endfunction : st
   task automatic close_out();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (4000) @(posedge clk);
      errors++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(REG_CONFIG, 32'h0);
      rdc(REG_STATUS, st(1'b0, 1'b0));
      wr(REG_CONFIG, 32'h1);
      wr(REG_OUT_CMD, 32'ha5c3);
      idle();
      chk({16'h0, points}, 32'ha5c3);
      chk({16'h0, point_leds}, 32'ha5c3);
      wr(REG_OUT_CMD, 32'h5a3c);
      rdc(REG_POINTS, 32'h5a3c);
      wr(REG_STATUS, 32'hffff);
      rdc(REG_STATUS, st(1'b1, 1'b0));
      wr(REG_IRQ_CLR, 32'hf);
      wr(REG_IRQ_EN, 32'h4);
      @(posedge clk) fld.terminal_present <= 1'b0;
      idle();
      chk({30'h0, term_led_green, term_led_red}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(REG_STATUS, st(1'b1, 1'b0));
      wr(REG_IRQ_CLR, 32'h4);
      idle();
      chk({31'h0, irq}, 32'h0);
      @(posedge clk) fld.terminal_present <= 1'b1;
      wr(REG_IRQ_CLR, 32'hf);
      wr(REG_CONFIG, 32'h0);
      idle();
      chk({16'h0, points}, 32'h0);
      rdc(REG_IRQ_STAT, 32'h2);
      @(posedge clk) fld.upper_switch_hold <= 1'b1;
      wr(REG_CONFIG, 32'h3);
      wr(REG_OUT_CMD, 32'h1234);
      wr(REG_CONFIG, 32'h2);
      @(posedge clk) fld.lower_switch <= 1'b1;
      idle();
      chk({16'h0, points}, 32'h1234);
      rdc(REG_STATUS, st(1'b0, 1'b1));
      @(posedge clk) fld.field_power <= 1'b0;
      idle();
      chk({16'h0, points}, 32'h0);
      rdc(REG_STATUS, st(1'b0, 1'b1));
      @(posedge clk) fld.field_power <= 1'b1;
      wr(REG_IRQ_CLR, 32'hf);
      wr(REG_IRQ_EN, 32'h1);
      wr(REG_CONFIG, 32'h1);
      idle();
      rdc(REG_STATUS, st(1'b1, 1'b0));
      chk({31'h0, irq}, 32'h1);
      wr(REG_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(8'h40, UNMAPPED_DATA);
      close_out();
   end
endmodule : tb_top
